//--- rtl/aspc_core.sv
// Full-duplex asynchronous serial port core with receive and transmit FIFOs.
// Operation
// [RQ1] Reference clock is the core clock divided by four.
// [RQ2] Reference divided by programmable 1..1024, then by 16, gives bit rate.
// [RQ3] Receive bit timing restarts on every edge of the input line.
// [RQ4] Each received bit is sampled after 8 of its 16 oversample ticks.
// [RQ5] Receiver strips start, parity and stop bits and stores the character.
// [RQ6] Enabled parity check flags a mismatch in the character's entry.
// [RQ7] A zero in the stop position flags a framing error in the entry.
// [RQ8] Arrival into a full receive FIFO sets the overrun flag.
// [RQ9] Disabled port with low input line raises the receive interrupt.
// [RQ10] Receive interrupt from more than half full, or any data when single-buffered.
// [RQ11] Receive interrupt after 32 idle bit periods with data waiting.
// [RQ12] Transmitter runs alongside receiver, framing and shifting FIFO characters.
// [RQ13] Empty transmit FIFO leaves the output line high.
// [RQ14] Transmit interrupt below half full, or empty holding buffer when single.
// [RQ15] Data read returns the oldest character and advances the FIFO.
// [RQ16] Data write pushes the character into the transmit FIFO.
// [RQ17] Short characters are zero-filled; upper data register bits read zero.
// [RQ18] Software reads the data before its error status.
// [RQ19] Frame: low start, 5 to 8 data bits LSB first, parity, 1-2 stops.
// [RQ20] Transmit FIFO 16 by 8 bits; receive FIFO 16 by 10 bits.
// [RQ21] Parity type one selects even parity, zero selects odd.
// [RQ22] A data register read clears the overrun flag.
// [RQ23] Above half means more than eight entries, below means fewer.
// [RQ24] After reset the port is disabled, FIFOs empty, output high.
`timescale 1ns/1ps
`include "aspc_map.svh"

module aspc_core #(
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire aspc_pkg::aspc_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic receive_service_interrupt,
  output logic transmit_service_interrupt
);
  import aspc_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************

  // Keeps only the low character bits of a byte for a given size code.
  function automatic logic [7:0] char_mask(input logic [7:0] d, input logic [1:0] wl);
    logic [7:0] m;
    m = 8'hff >> (2'd3 - wl);
    return d & m;
  endfunction

  // Parity bit that makes the character meet the chosen parity type.
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl, input logic even);
    return (^char_mask(d, wl)) ^ ~even;
  endfunction

  // ****************************************
  // Registers and bus access
  // ****************************************
  logic [6:0] line_ff, nxt_line;
  logic [9:0] div_ff, nxt_div;
  logic en_ff, nxt_en;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] err_ff, nxt_err;
  logic ore_ff, nxt_ore;
  logic rd_data, wr_data;
  logic [1:0] wlen;
  logic [3:0] nbits_m1;
  logic [4:0] limit;
  logic rx_push, rx_full, tx_pop;
  aspc_rx_entry_s rx_head, rx_new;
  logic [4:0] rx_cnt_ff, tx_cnt_ff;

  assign wlen = line_ff[`ASPC_BIT_WLEN +: 2];
  assign nbits_m1 = {2'b01, wlen};
  // Single buffering simply caps both FIFOs at one entry.
  assign limit = line_ff[`ASPC_BIT_FIFOEN] ? 5'(DEPTH) : 5'd1;
  assign rd_data = bus_req.sel && !bus_req.wr && bus_req.addr == `ASPC_OFF_DATA;
  assign wr_data = bus_req.sel && bus_req.wr && bus_req.addr == `ASPC_OFF_DATA;

  // Register writes, read data and the status that reads change.
  always_comb begin
    nxt_line = line_ff;
    nxt_div = div_ff;
    nxt_en = en_ff;
    nxt_rdata = rdata_ff;
    nxt_err = err_ff;
    nxt_ore = ore_ff;
    if (bus_req.sel && bus_req.wr) begin
      if (bus_req.addr == `ASPC_OFF_LINE) nxt_line = bus_req.wdata[6:0];
      if (bus_req.addr == `ASPC_OFF_DIV) nxt_div = bus_req.wdata[9:0];
      if (bus_req.addr == `ASPC_OFF_PORT) nxt_en = bus_req.wdata[`ASPC_BIT_ENABLE];
    end
    if (bus_req.sel && !bus_req.wr) begin
      nxt_rdata = 32'h0000_0000;
      unique case (bus_req.addr)
        // [RQ15] [RQ17] oldest character, zero-filled
        `ASPC_OFF_DATA: nxt_rdata[7:0] = rx_cnt_ff != 5'd0 ? rx_head.data : 8'h00;
        `ASPC_OFF_RECEIVE_ERROR_STATUS: nxt_rdata[2:0] = {ore_ff, err_ff[1], err_ff[0]};
        `ASPC_OFF_LINE: nxt_rdata[6:0] = line_ff;
        `ASPC_OFF_DIV: nxt_rdata[9:0] = div_ff;
        `ASPC_OFF_PORT: nxt_rdata[0] = en_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    // [RQ18] error bits follow the character just read
    if (rd_data) nxt_err = rx_cnt_ff != 5'd0 ? {rx_head.pe, rx_head.fe} : 2'b00;
    // [RQ22] data read clears overrun
    if (rd_data) nxt_ore = 1'b0;
    // [RQ8] overrun set wins over clear
    if (rx_push && rx_full) nxt_ore = 1'b1;
  end

  // [RQ24] port comes up disabled.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_ff <= `ASPC_RST_LINE;
      div_ff <= `ASPC_RST_DIV;
      en_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      err_ff <= 2'b00;
      ore_ff <= 1'b0;
    end else begin
      line_ff <= nxt_line;
      div_ff <= nxt_div;
      en_ff <= nxt_en;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
      ore_ff <= nxt_ore;
    end
  end
  assign bus_rdata = rdata_ff;

  // ****************************************
  // Baud generation
  // ****************************************
  logic [1:0] pre_ff, nxt_pre;
  logic [9:0] bdiv_ff, nxt_bdiv;
  logic os_tick;

  // Counters stay free-running; a divisor change applies to the count already in progress.
  always_comb begin
    // [RQ1] fixed divide by four
    nxt_pre = pre_ff + 2'd1;
    nxt_bdiv = bdiv_ff;
    // [RQ2] programmable divide, register holds divisor minus one
    if (pre_ff == `ASPC_REF_DIV) nxt_bdiv = bdiv_ff >= div_ff ? 10'd0 : bdiv_ff + 10'd1;
  end
  assign os_tick = pre_ff == `ASPC_REF_DIV && bdiv_ff >= div_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff <= 2'd0;
      bdiv_ff <= 10'd0;
    end else begin
      pre_ff <= nxt_pre;
      bdiv_ff <= nxt_bdiv;
    end
  end

  // ****************************************
  // FIFOs
  // ****************************************
  aspc_rx_entry_s rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [PTR_W-1:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
  logic [4:0] nxt_rx_cnt, nxt_tx_cnt;
  logic rx_pop, tx_push;

  // [RQ20] sixteen entries each, error bits kept with the character
  assign rx_full = rx_cnt_ff >= limit;
  assign rx_head = rx_mem[rx_rp_ff];
  assign rx_pop = rd_data && rx_cnt_ff != 5'd0;
  // A write into a full transmit FIFO is dropped rather than corrupting queued data.
  assign tx_push = wr_data && tx_cnt_ff < limit;

  // Occupancy counts.
  always_comb begin
    nxt_rx_cnt = rx_cnt_ff + 5'(rx_push && !rx_full) - 5'(rx_pop);
    nxt_tx_cnt = tx_cnt_ff + 5'(tx_push) - 5'(tx_pop);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt_ff <= 5'd0;
      tx_cnt_ff <= 5'd0;
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
    end else begin
      rx_cnt_ff <= nxt_rx_cnt;
      tx_cnt_ff <= nxt_tx_cnt;
      // [RQ5] store stripped character
      if (rx_push && !rx_full) rx_wp_ff <= rx_wp_ff + 1'b1;
      // [RQ15] advance to next entry
      if (rx_pop) rx_rp_ff <= rx_rp_ff + 1'b1;
      // [RQ16] write goes into FIFO
      if (tx_push) tx_wp_ff <= tx_wp_ff + 1'b1;
      if (tx_pop) tx_rp_ff <= tx_rp_ff + 1'b1;
    end
  end

  // Storage carries no reset; only the pointers and occupancy counts define what is valid.
  always_ff @(posedge clk) begin
    if (rx_push && !rx_full) rx_mem[rx_wp_ff] <= rx_new;
    if (tx_push) tx_mem[tx_wp_ff] <= bus_req.wdata[7:0];
  end

  // ****************************************
  // Receiver
  // ****************************************
  logic rx_m_ff, rx_s_ff, rx_q_ff;
  aspc_state_e rx_st_ff, nxt_rx_st;
  logic [3:0] rx_ph_ff, nxt_rx_ph, rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic rx_pe_ff, nxt_rx_pe;
  logic rx_samp, rx_edge;

  assign rx_edge = rx_s_ff != rx_q_ff;
  // [RQ4] mid-bit sample after eight ticks
  assign rx_samp = os_tick && rx_ph_ff == `ASPC_SAMPLE_PHASE;

  // Frame unpacking.
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_ph = os_tick ? rx_ph_ff + 4'd1 : rx_ph_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_pe = rx_pe_ff;
    rx_push = 1'b0;
    rx_new = '0;
    // [RQ3] resync bit timing on every edge
    if (rx_edge) nxt_rx_ph = 4'd0;
    unique case (rx_st_ff)
      ASPC_IDLE: begin
        nxt_rx_ph = 4'd0;
        // [RQ19] falling edge opens a frame
        if (en_ff && rx_edge && !rx_s_ff) nxt_rx_st = ASPC_START;
      end
      ASPC_START: begin
        // A start that is high again at mid-bit was a glitch.
        if (rx_samp) nxt_rx_st = rx_s_ff ? ASPC_IDLE : ASPC_DATA;
        nxt_rx_bit = 4'd0;
        nxt_rx_pe = 1'b0;
      end
      ASPC_DATA: if (rx_samp) begin
        // [RQ19] least significant bit first
        nxt_rx_sh = {rx_s_ff, rx_sh_ff[7:1]};
        nxt_rx_bit = rx_bit_ff + 4'd1;
        if (rx_bit_ff == nbits_m1) nxt_rx_st = line_ff[`ASPC_BIT_PCHK] ? ASPC_PAR : ASPC_STOP;
      end
      ASPC_PAR: if (rx_samp) begin
        // [RQ6] [RQ21] parity compare
        nxt_rx_pe = rx_s_ff != par_bit(rx_sh_ff >> (3'd7 - 3'(nbits_m1)), wlen, line_ff[`ASPC_BIT_PTYPE]);
        nxt_rx_st = ASPC_STOP;
      end
      ASPC_STOP: if (rx_samp) begin
        // [RQ5] [RQ17] align and zero-fill
        rx_new.data = char_mask(rx_sh_ff >> (3'd7 - 3'(nbits_m1)), wlen);
        rx_new.pe = rx_pe_ff;
        // [RQ7] zero in stop position
        rx_new.fe = !rx_s_ff;
        rx_push = 1'b1;
        nxt_rx_st = ASPC_IDLE;
      end
      default: nxt_rx_st = ASPC_IDLE;
    endcase
    if (!en_ff) nxt_rx_st = ASPC_IDLE;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_m_ff <= 1'b1;
      rx_s_ff <= 1'b1;
      rx_q_ff <= 1'b1;
      rx_st_ff <= ASPC_IDLE;
      rx_ph_ff <= 4'd0;
      rx_bit_ff <= 4'd0;
      rx_sh_ff <= 8'h00;
      rx_pe_ff <= 1'b0;
    end else begin
      rx_m_ff <= rx_pin;
      rx_s_ff <= rx_m_ff;
      rx_q_ff <= rx_s_ff;
      rx_st_ff <= nxt_rx_st;
      rx_ph_ff <= nxt_rx_ph;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_pe_ff <= nxt_rx_pe;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  aspc_state_e tx_st_ff, nxt_tx_st;
  logic [3:0] tx_ph_ff, nxt_tx_ph, tx_bit_ff, nxt_tx_bit;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic tx_par_ff, nxt_tx_par, tx_ff, nxt_tx, tx_stop2_ff, nxt_tx_stop2;
  logic tx_end;

  assign tx_end = os_tick && tx_ph_ff == `ASPC_LAST_PHASE;
  // [RQ12] fetch only between frames; break stops fetching
  // Fetching on an oversample tick keeps the start bit a full sixteen ticks long.
  assign tx_pop = tx_st_ff == ASPC_IDLE && en_ff && !line_ff[`ASPC_BIT_BRK] && tx_cnt_ff != 5'd0 && os_tick;

  // Frame building; break is honoured only between frames.
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_ph = os_tick ? tx_ph_ff + 4'd1 : tx_ph_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tx_stop2 = tx_stop2_ff;
    nxt_tx = tx_ff;
    unique case (tx_st_ff)
      ASPC_IDLE: begin
        nxt_tx_ph = 4'd0;
        nxt_tx_bit = 4'd0;
        // [RQ13] idle high, low only for break
        nxt_tx = !(en_ff && line_ff[`ASPC_BIT_BRK]);
        if (tx_pop) begin
          nxt_tx_sh = tx_mem[tx_rp_ff];
          // [RQ21] generated parity
          nxt_tx_par = par_bit(tx_mem[tx_rp_ff], wlen, line_ff[`ASPC_BIT_PTYPE]);
          nxt_tx_stop2 = line_ff[`ASPC_BIT_STOP2];
          nxt_tx_st = ASPC_START;
          // [RQ19] start bit low
          nxt_tx = 1'b0;
        end
      end
      ASPC_START: if (tx_end) begin
        nxt_tx_st = ASPC_DATA;
        nxt_tx = tx_sh_ff[0];
      end
      ASPC_DATA: if (tx_end) begin
        nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
        nxt_tx_bit = tx_bit_ff + 4'd1;
        nxt_tx = tx_sh_ff[1];
        if (tx_bit_ff == nbits_m1) begin
          nxt_tx_st = line_ff[`ASPC_BIT_PCHK] ? ASPC_PAR : ASPC_STOP;
          nxt_tx = line_ff[`ASPC_BIT_PCHK] ? tx_par_ff : 1'b1;
        end
      end
      ASPC_PAR: if (tx_end) begin
        nxt_tx_st = ASPC_STOP;
        nxt_tx = 1'b1;
      end
      ASPC_STOP: if (tx_end) begin
        // [RQ19] one or two stop bits
        nxt_tx_stop2 = 1'b0;
        if (!tx_stop2_ff) nxt_tx_st = ASPC_IDLE;
      end
      default: nxt_tx_st = ASPC_IDLE;
    endcase
    if (!en_ff) begin
      nxt_tx_st = ASPC_IDLE;
      nxt_tx = 1'b1;
    end
  end

  // [RQ24] output line high from reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_ff <= ASPC_IDLE;
      tx_ph_ff <= 4'd0;
      tx_bit_ff <= 4'd0;
      tx_sh_ff <= 8'h00;
      tx_par_ff <= 1'b0;
      tx_stop2_ff <= 1'b0;
      tx_ff <= 1'b1;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_ph_ff <= nxt_tx_ph;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_par_ff <= nxt_tx_par;
      tx_stop2_ff <= nxt_tx_stop2;
      tx_ff <= nxt_tx;
    end
  end
  assign tx_pin = tx_ff;

  // ****************************************
  // Timeout and service interrupts
  // ****************************************
  logic [9:0] tmo_ff, nxt_tmo;
  logic rxi_ff, nxt_rxi, txi_ff, nxt_txi;

  // Interrupt levels are recomputed every cycle; no sticky state is needed.
  always_comb begin
    nxt_tmo = tmo_ff;
    // [RQ11] idle time since last character
    if (!en_ff || rx_cnt_ff == 5'd0 || rx_st_ff != ASPC_IDLE || rx_pop) nxt_tmo = 10'd0;
    else if (os_tick && tmo_ff <= 10'(`ASPC_TMO_TICKS)) nxt_tmo = tmo_ff + 10'd1;
    // [RQ9] disabled port, low line
    nxt_rxi = !en_ff && !rx_s_ff;
    // [RQ10] [RQ23] more than eight, or any when single
    if (en_ff && line_ff[`ASPC_BIT_FIFOEN] && rx_cnt_ff > `ASPC_HALF) nxt_rxi = 1'b1;
    if (en_ff && !line_ff[`ASPC_BIT_FIFOEN] && rx_cnt_ff != 5'd0) nxt_rxi = 1'b1;
    // [RQ11] timeout expired
    if (tmo_ff > 10'(`ASPC_TMO_TICKS)) nxt_rxi = 1'b1;
    // [RQ14] [RQ23] fewer than eight, or empty holding buffer
    nxt_txi = line_ff[`ASPC_BIT_FIFOEN] ? tx_cnt_ff < `ASPC_HALF : tx_cnt_ff == 5'd0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmo_ff <= 10'd0;
      rxi_ff <= 1'b0;
      txi_ff <= 1'b0;
    end else begin
      tmo_ff <= nxt_tmo;
      rxi_ff <= nxt_rxi;
      txi_ff <= nxt_txi;
    end
  end
  assign receive_service_interrupt = rxi_ff;
  assign transmit_service_interrupt = txi_ff;

endmodule // aspc_core

//--- rtl/aspc_map.svh
// Register offsets, field positions, reset values and timing counts of the serial port core.
`ifndef ASPC_MAP_SVH
`define ASPC_MAP_SVH
`define ASPC_OFF_DATA 12'h160
`define ASPC_OFF_RECEIVE_ERROR_STATUS 12'h164
`define ASPC_OFF_LINE 12'h168
`define ASPC_OFF_DIV 12'h16c
`define ASPC_OFF_PORT 12'h170
`define ASPC_BIT_FE 0
`define ASPC_BIT_PE 1
`define ASPC_BIT_ORE 2
`define ASPC_BIT_BRK 0
`define ASPC_BIT_PCHK 1
`define ASPC_BIT_PTYPE 2
`define ASPC_BIT_STOP2 3
`define ASPC_BIT_WLEN 4
`define ASPC_BIT_FIFOEN 6
`define ASPC_BIT_ENABLE 0
`define ASPC_RST_LINE 7'h00
`define ASPC_RST_DIV 10'h000
`define ASPC_REF_DIV 2'd3
`define ASPC_OS_PER_BIT 16
`define ASPC_SAMPLE_PHASE 4'd7
`define ASPC_LAST_PHASE 4'd15
`define ASPC_TMO_BITS 32
`define ASPC_TMO_TICKS (`ASPC_TMO_BITS * `ASPC_OS_PER_BIT)
`define ASPC_HALF 5'd8
`endif

//--- rtl/aspc_pkg.sv
// Types shared by the serial port core.
package aspc_pkg;
  typedef enum logic [2:0] {
    ASPC_IDLE = 3'b000,
    ASPC_START = 3'b001,
    ASPC_DATA = 3'b011,
    ASPC_PAR = 3'b010,
    ASPC_STOP = 3'b110
  } aspc_state_e;
  typedef struct packed {
    logic fe;
    logic pe;
    logic [7:0] data;
  } aspc_rx_entry_s;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } aspc_bus_req_s;
endpackage

//--- verif/aspc_core_monitor.sv
// Concurrent checks on the serial port core's pins.
`timescale 1ns/1ps
`include "aspc_map.svh"
module aspc_core_monitor #(
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire aspc_pkg::aspc_bus_req_s bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic receive_service_interrupt,
  input wire logic transmit_service_interrupt
);
  import aspc_pkg::*;
  // ****
  // Helper state
  // ****
  logic en_ff;
  logic nxt_en;
  logic [15:0] lo_ff;
  logic [15:0] nxt_lo;
  // Mirror the port enable and count low cycles on the output line.
  always_comb begin
    nxt_en = en_ff;
    if (bus_req.sel && bus_req.wr && bus_req.addr == `ASPC_OFF_PORT) begin
      nxt_en = bus_req.wdata[`ASPC_BIT_ENABLE];
    end
    nxt_lo = tx_pin ? 16'h0 : lo_ff + 16'h1;
  end
  // Registers only.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_ff <= 1'b0;
      lo_ff <= 16'h0;
    end else begin
      en_ff <= nxt_en;
      lo_ff <= nxt_lo;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  tx_rst_idle_a: assert property ($rose(reset_n) |-> tx_pin && bus_rdata == 32'h0)
    else $error("output line or read data not idle after reset");
  txirq_rst_a: assert property ($rose(reset_n) |-> ##[0:2] transmit_service_interrupt)
    else $error("transmit interrupt missing with empty FIFO");
  tx_bit_len_a: assert property ($rose(tx_pin) |-> lo_ff != 16'h0 && lo_ff[5:0] == 6'h0)
    else $error("low run on output line not a whole number of bit periods");
  rx_wake_a: assert property (!en_ff && $fell(rx_pin) |-> ##[1:5] receive_service_interrupt)
    else $error("receive interrupt missing on low line while disabled");
  tx_dis_high_a: assert property (!en_ff && !$past(en_ff) |-> tx_pin)
    else $error("output line low while port disabled");
  tx_en_only_a: assert property ($fell(tx_pin) |-> $past(en_ff))
    else $error("frame started while port disabled");
  upper_zero_a: assert property (bus_req.sel && !bus_req.wr && bus_req.addr == `ASPC_OFF_DATA
    |=> bus_rdata[31:8] == 24'h0) else $error("data read upper bits not zero");
  rdata_hold_a: assert property (!(bus_req.sel && !bus_req.wr) |=> $stable(bus_rdata))
    else $error("read data changed without a read");
endmodule // aspc_core_monitor
bind aspc_core aspc_core_monitor #(.DEPTH(DEPTH), .PTR_W(PTR_W)) i_mon (.clk(clk), .reset_n(reset_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .receive_service_interrupt(receive_service_interrupt), .transmit_service_interrupt(transmit_service_interrupt));

//--- verif/aspc_far_end.sv
// Remote serial device model on the port's serial pins.
`timescale 1ns/1ps
module aspc_far_end #(
  parameter int BIT = 64
) (
  input wire logic clk,
  input wire logic tx_pin,
  output logic rx_pin,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic par_even,
  input wire logic stop2,
  output logic got,
  output logic [8:0] got_word
);
  // ****
  // Line model
  // ****
  logic [7:0] sh;
  logic bad;
  int i;
  // The line idles high, as a pulled-up wire would.
  initial begin
    rx_pin = 1'b1;
    got = 1'b0;
    got_word = 9'h0;
  end
  task automatic bit_out(input logic v);
    rx_pin <= v;
    repeat (BIT) @(posedge clk);
  endtask
  task automatic level(input logic v);
    rx_pin <= v;
  endtask
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    int k;
    bit_out(1'b0);
    for (k = 0; k < nbits; k++) bit_out(d[k]);
    if (par_en) bit_out(^d ^ ~par_even ^ bad_par);
    bit_out(~bad_stop);
    if (stop2) bit_out(1'b1);
    bit_out(1'b1);
  endtask
  // frame decode; any slip in start, parity or stop marks the word bad.
  always begin
    @(negedge tx_pin);
    repeat (BIT / 2) @(posedge clk);
    bad = tx_pin;
    sh = 8'h0;
    for (i = 0; i < nbits; i++) begin
      repeat (BIT) @(posedge clk);
      sh[i] = tx_pin;
    end
    if (par_en) begin
      repeat (BIT) @(posedge clk);
      bad = bad | ((^sh ^ tx_pin) !== ~par_even);
    end
    repeat (BIT) @(posedge clk);
    bad = bad | ~tx_pin;
    if (stop2) begin
      repeat (BIT) @(posedge clk);
      bad = bad | ~tx_pin;
    end
    got <= 1'b1;
    got_word <= {bad, sh};
    @(posedge clk);
    got <= 1'b0;
  end
endmodule // aspc_far_end

//--- verif/tb_aspc_core.sv
// Self-checking bench for the serial port core.
`timescale 1ns/1ps
`include "aspc_map.svh"
module tb_aspc_core;
  import aspc_pkg::*;
  // ****
  // Bench
  // ****
  logic clk;
  logic reset_n;
  aspc_bus_req_s bus_req;
  logic [31:0] bus_rdata;
  logic rx_pin;
  logic tx_pin;
  logic rxi;
  logic txi;
  logic [3:0] nbits;
  logic par_en;
  logic par_even;
  logic stop2;
  logic got;
  logic [8:0] got_word;
  logic took;
  logic [31:0] exp_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] d;
  logic [7:0] e;
  logic [7:0] keep[16];
  integer seed;
  int n_mismatch;
  int checks;
  int m;
  int k;
  aspc_core i_dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .receive_service_interrupt(rxi), .transmit_service_interrupt(txi));
  aspc_far_end i_far (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin), .nbits(nbits), .par_en(par_en),
    .par_even(par_even), .stop2(stop2), .got(got), .got_word(got_word));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{sel: 1'b1, wr: 1'b1, addr: a, wdata: v};
    @(posedge clk);
    bus_req.sel <= 1'b0;
  endtask
  // The expected word is queued; the watcher compares it a cycle after the strobe.
  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    exp_q.push_back(v);
    @(posedge clk);
    bus_req.sel <= 1'b0;
  endtask
  task automatic cfg(input logic [1:0] sz, input logic pe, input logic pt, input logic s2, input logic fe);
    wr(`ASPC_OFF_LINE, {25'h0, fe, sz, s2, pt, pe, 1'b0});
    nbits = 4'd5 + sz;
    par_en = pe;
    par_even = pt;
    stop2 = s2;
  endtask
  task automatic wait_tx();
    for (k = 0; k < 9000 && tx_q.size() != 0; k++) @(posedge clk);
    chk("tx_drain", tx_q.size(), 32'h0);
  endtask
  function automatic logic [7:0] msk();
    return 8'((9'h1 << nbits) - 9'h1);
  endfunction
  // Results that appear are matched against the oldest note.
  always @(posedge clk) begin
    if (took) chk("rdata", bus_rdata, exp_q.pop_front());
    took <= bus_req.sel & ~bus_req.wr;
    if (got) chk("tx_frame", {23'h0, got_word}, {24'h0, tx_q.pop_front()});
  end
  // A hang counts as a mismatch.
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    bus_req = '0;
    {nbits, par_en, par_even, stop2, took} = {4'h8, 4'h0};
    seed = 32'h50b7;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("tx_pin", {31'h0, tx_pin}, 32'h1);
    chk("tx_irq", {31'h0, txi}, 32'h1);
    rd(`ASPC_OFF_DATA, 32'h0);
    rd(12'h174, 32'h0);
    i_far.level(1'b0);
    repeat (8) @(posedge clk);
    chk("rx_wake", {31'h0, rxi}, 32'h1);
    i_far.level(1'b1);
    repeat (8) @(posedge clk);
    chk("rx_wake_end", {31'h0, rxi}, 32'h0);
    wr(`ASPC_OFF_DIV, 32'h0);
    wr(`ASPC_OFF_PORT, 32'h1);
    // Every size, both parity senses and stop counts, one parity and one stop fault, both ways at once.
    for (m = 0; m < 8; m++) begin
      cfg(m[1:0], m[2] | m[0], m[1], m[2], 1'b1);
      d = 8'($random(seed));
      e = d & msk();
      tx_q.push_back(e);
      wr(`ASPC_OFF_DATA, {24'h0, d});
      i_far.send(e, m == 5, m == 6);
      rd(`ASPC_OFF_DATA, {24'h0, e});
      rd(`ASPC_OFF_RECEIVE_ERROR_STATUS, {30'h0, m == 5, m == 6});
      wait_tx();
    end
    // Ten quick writes leave more than half the transmit FIFO occupied.
    cfg(2'h3, 1'b0, 1'b0, 1'b0, 1'b1);
    for (k = 0; k < 10; k++) begin
      d = 8'($random(seed));
      tx_q.push_back(d);
      wr(`ASPC_OFF_DATA, {24'h0, d});
    end
    repeat (2) @(posedge clk);
    chk("tx_irq_full", {31'h0, txi}, 32'h0);
    // Seventeen arrivals overrun the receive FIFO while the transmitter drains.
    for (m = 0; m < 17; m++) begin
      d = 8'($random(seed));
      if (m < 16) keep[m] = d;
      i_far.send(d, 1'b0, 1'b0);
      if (m == 7 || m == 8) chk("rx_half", {31'h0, rxi}, {31'h0, m == 8});
    end
    // Overrun is read first, since the data read that follows clears it.
    rd(`ASPC_OFF_RECEIVE_ERROR_STATUS, 32'h4);
    rd(`ASPC_OFF_DATA, {24'h0, keep[0]});
    rd(`ASPC_OFF_RECEIVE_ERROR_STATUS, 32'h0);
    for (m = 1; m < 16; m++) begin
      rd(`ASPC_OFF_DATA, {24'h0, keep[m]});
      rd(`ASPC_OFF_RECEIVE_ERROR_STATUS, 32'h0);
    end
    wait_tx();
    // One waiting character must wake the reader after 32 quiet bit periods, not before.
    i_far.send(8'h5a, 1'b0, 1'b0);
    repeat (1700) @(posedge clk);
    chk("rx_quiet", {31'h0, rxi}, 32'h0);
    for (k = 0; k < 800 && rxi !== 1'b1; k++) @(posedge clk);
    chk("rx_timeout", {31'h0, rxi}, 32'h1);
    rd(`ASPC_OFF_DATA, 32'h5a);
    // Single buffering: one character raises the receive interrupt, the read clears it.
    cfg(2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    i_far.send(8'hc3, 1'b0, 1'b0);
    chk("rx_single", {31'h0, rxi}, 32'h1);
    rd(`ASPC_OFF_DATA, 32'hc3);
    repeat (3) @(posedge clk);
    chk("rx_single_clr", {31'h0, rxi}, 32'h0);
    chk("tx_single", {31'h0, txi}, 32'h1);
    // Break pulls the idle line low; nothing is fetched while it stands.
    wr(`ASPC_OFF_LINE, 32'h1);
    repeat (3) @(posedge clk);
    chk("tx_break", {31'h0, tx_pin}, 32'h0);
    results();
  end
endmodule // tb_aspc_core
